//--- logic/otf_fault_top.sv
/*
 * otf_fault_top: over-current and over-temperature fault handling of a
 * buck regulator, with duty limiting, hiccup and current/temperature
 * telemetry.
 * Assumes the fast comparator, ADC current and die temperature arrive
 * synchronous to clk; configuration inputs are held by the host side.
 */
`timescale 1ns/1ps
module otf_fault_top
    import otf_pkg::*;
#(
    parameter int SW_PERIOD = SW_PERIOD_DEFAULT,
    parameter int HICCUP_CYCLES = HICCUP_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic conv_enable,
    input wire logic oc_comp,
    input wire logic [11:0] iout_code,
    input wire logic [7:0] die_temp_c,
    input wire logic [11:0] oc_warn_limit,
    input wire logic [3:0] oc_max_count,
    input wire logic [1:0] oc_response,
    input wire logic [7:0] ot_limit,
    input wire logic [2:0] ot_response,
    input wire logic [7:0] duty_nominal,
    input wire logic [2:0] status_clear,
    output logic high_side_drive,
    output logic low_side_drive,
    output logic set_pulse,
    output logic conv_active,
    output logic hiccup_active,
    output logic [1:0] duty_limit_level,
    output logic [11:0] read_iout,
    output logic [7:0] load_current_quarter_amp,
    output logic [7:0] read_temperature,
    output logic [7:0] die_heat_offset_reading,
    output logic oc_warn_flag,
    output logic oc_fault_flag,
    output logic ot_fault_flag
);

    localparam int HW = $clog2(HICCUP_CYCLES + 1);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    generate
        if (HICCUP_CYCLES < 1) begin : g_bad
            $error("otf_fault_top: HICCUP_CYCLES must be at least one");
        end
    endgenerate

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] duty_cap(input logic [1:0] level);
        case (level)
            2'h1: duty_cap = DUTY_HALF;
            2'h2: duty_cap = DUTY_QUARTER;
            2'h3: duty_cap = DUTY_EIGHTH;
            default: duty_cap = DUTY_FULL;
        endcase
    endfunction

    otf_state_t state_q;
    otf_state_t state_d;
    logic [HW-1:0] hiccup_cnt_q;
    logic oc_seen_q;
    logic [3:0] oc_total_q;
    logic [2:0] oc_run_q;
    logic [2:0] ok_run_q;
    logic [1:0] level_q;
    logic [7:0] duty_eff;
    logic sample_win;
    logic cycle_end;
    logic oc_cycle;
    logic ok_cycle;
    logic oc_fault_now;
    logic ot_trip;
    logic ot_release;
    logic ot_acts;
    logic hiccup_done;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] flag_q;

    // ****************************************************************
    // fault detection
    // ****************************************************************
    always_comb begin
        oc_cycle = cycle_end && oc_seen_q;
        ok_cycle = cycle_end && !oc_seen_q;
        // a zero maximum trips on the first over-current cycle, so it behaves as one
        oc_fault_now = oc_cycle && (({1'b0, oc_total_q} + 5'h01) >= {1'b0, oc_max_count}
            || oc_max_count == 4'h0);
        ot_trip = die_temp_c > ot_limit;
        ot_release = ({1'b0, die_temp_c} + OT_HYST) < {1'b0, ot_limit};
        ot_acts = ot_trip && ot_response != OTF_OTR_IGNORE;
        hiccup_done = hiccup_cnt_q == HW'(HICCUP_CYCLES - 1);
        duty_eff = (duty_nominal < duty_cap(level_q)) ? duty_nominal : duty_cap(level_q);
    end

    // valley trip caught inside the sampling window only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oc_seen_q <= 1'b0;
        end else if (sample_win && oc_comp) begin
            oc_seen_q <= 1'b1;
        end else if (cycle_end || !conv_active) begin
            oc_seen_q <= 1'b0;
        end
    end

    // ****************************************************************
    // fault state machine
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            OTF_ST_RUN: begin
                if (ot_acts) begin
                    state_d = (ot_response == OTF_OTR_LATCH) ? OTF_ST_LATCHED
                        : OTF_ST_OT_HOLD;
                end else if (oc_fault_now && conv_active) begin
                    state_d = (oc_response == OTF_OCR_LATCH) ? OTF_ST_LATCHED
                        : OTF_ST_HICCUP;
                end
            end
            OTF_ST_HICCUP: begin
                if (ot_acts) begin
                    state_d = (ot_response == OTF_OTR_LATCH) ? OTF_ST_LATCHED
                        : OTF_ST_OT_HOLD;
                end else if (hiccup_done) begin
                    state_d = OTF_ST_RUN;
                end
            end
            OTF_ST_OT_HOLD: begin
                if (ot_response == OTF_OTR_LATCH) begin
                    state_d = OTF_ST_LATCHED;
                end else if (ot_release || ot_response == OTF_OTR_IGNORE) begin
                    state_d = OTF_ST_RUN;
                end
            end
            OTF_ST_LATCHED: begin
                if (!conv_enable) begin
                    state_d = OTF_ST_RUN;
                end
            end
            default: state_d = OTF_ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= OTF_ST_RUN;
            conv_active <= 1'b0;
            hiccup_active <= 1'b0;
        end else begin
            state_q <= state_d;
            // conversion enable drops for every non-run state
            conv_active <= state_d == OTF_ST_RUN && conv_enable;
            hiccup_active <= state_d == OTF_ST_HICCUP;
        end
    end

    // 20 ms off time, counted only while in hiccup
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hiccup_cnt_q <= '0;
        end else if (state_q == OTF_ST_HICCUP && !hiccup_done) begin
            hiccup_cnt_q <= hiccup_cnt_q + HW'(1);
        end else begin
            hiccup_cnt_q <= '0;
        end
    end

    // ****************************************************************
    // over-current counting and duty limiting
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oc_total_q <= 4'h0;
        end else if (!conv_active) begin
            oc_total_q <= 4'h0;
        end else if (oc_cycle && oc_total_q != 4'hf) begin
            // cumulative: clean cycles do not reset the total
            oc_total_q <= oc_total_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oc_run_q <= 3'h0;
            ok_run_q <= 3'h0;
            level_q <= LIMIT_NONE;
        end else if (!conv_active) begin
            oc_run_q <= 3'h0;
            ok_run_q <= 3'h0;
            level_q <= LIMIT_NONE;
        end else if (oc_cycle) begin
            ok_run_q <= 3'h0;
            if (level_q == LIMIT_NONE && duty_nominal < DUTY_EIGHTH) begin
                oc_run_q <= 3'h0;
            end else if (oc_run_q == OC_STEP_RUN - 3'h1) begin
                oc_run_q <= 3'h0;
                if (level_q != LIMIT_DEEPEST) begin
                    level_q <= level_q + 2'h1;
                end
            end else begin
                oc_run_q <= oc_run_q + 3'h1;
            end
        end else if (ok_cycle) begin
            oc_run_q <= 3'h0;
            if (level_q == LIMIT_NONE) begin
                ok_run_q <= 3'h0;
            end else if (ok_run_q == OC_RECOVER_RUN - 3'h1) begin
                ok_run_q <= 3'h0;
                level_q <= level_q - 2'h1;
            end else begin
                ok_run_q <= ok_run_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            duty_limit_level <= LIMIT_NONE;
        end else begin
            duty_limit_level <= level_q;
        end
    end

    // ****************************************************************
    // sticky status flags
    // ****************************************************************
    always_comb begin
        flag_set[FLAG_OC_WARN] = iout_code > oc_warn_limit;
        flag_set[FLAG_OC_FAULT] = oc_fault_now && conv_active;
        flag_set[FLAG_OT_FAULT] = ot_trip;
    end

    // a set in the same cycle as a clear wins
    generate
        for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    flag_q[i] <= 1'b0;
                end else if (flag_set[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (status_clear[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        oc_warn_flag = flag_q[FLAG_OC_WARN];
        oc_fault_flag = flag_q[FLAG_OC_FAULT];
        ot_fault_flag = flag_q[FLAG_OT_FAULT];
    end

    // ****************************************************************
    // switching timer and telemetry
    // ****************************************************************
    otf_sw_timer #(
        .PERIOD(SW_PERIOD)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .run(conv_active),
        .duty(duty_eff),
        .set_pulse(set_pulse),
        .sample_win(sample_win),
        .cycle_end(cycle_end),
        .high_side_drive(high_side_drive),
        .low_side_drive(low_side_drive)
    );

    otf_telemetry u_tele (
        .clk(clk),
        .reset_n(reset_n),
        .iout_code(iout_code),
        .die_temp_c(die_temp_c),
        .read_iout(read_iout),
        .load_current_quarter_amp(load_current_quarter_amp),
        .read_temperature(read_temperature),
        .die_heat_offset_reading(die_heat_offset_reading)
    );

endmodule

//--- logic/otf_pkg.sv
/*
 * otf_pkg: constants, encodings and state codes of the over-current and
 * over-temperature fault logic.
 * Assumes a 100 MHz system clock; the timing figures below derive from it.
 */
package otf_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_NS = 75;
    // least sampling time, rounded up to whole cycles
    localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HICCUP_MS = 20;
    localparam int HICCUP_CYC = HICCUP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SW_PERIOD_DEFAULT = 100;
    localparam int SET_FRACTION = 8;

    // ****************************************************************
    // over-current limiting
    // ****************************************************************
    localparam logic [3:0] OC_MAX_DEFAULT = 4'h8;
    localparam logic [2:0] OC_STEP_RUN = 3'h3;
    localparam logic [2:0] OC_RECOVER_RUN = 3'h4;
    localparam logic [7:0] DUTY_HALF = 8'h80;
    localparam logic [7:0] DUTY_QUARTER = 8'h40;
    localparam logic [7:0] DUTY_EIGHTH = 8'h20;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [1:0] LIMIT_NONE = 2'h0;
    localparam logic [1:0] LIMIT_DEEPEST = 2'h3;

    // ****************************************************************
    // temperature and telemetry
    // ****************************************************************
    localparam logic [7:0] OT_LIMIT_DEFAULT = 8'h7d;
    localparam logic [8:0] OT_HYST = 9'h019;
    localparam logic [7:0] TEMP_OFFSET = 8'h28;
    localparam logic [7:0] TEMP_STEP = 8'h0a;
    localparam logic [11:0] IOUT_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ****************************************************************
    // encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        OTF_OCR_LATCH = 2'b01,
        OTF_OCR_HICCUP = 2'b10
    } otf_oc_resp_t;

    typedef enum logic [2:0] {
        OTF_OTR_IGNORE = 3'b001,
        OTF_OTR_INHIBIT = 3'b010,
        OTF_OTR_LATCH = 3'b100
    } otf_ot_resp_t;

    typedef enum logic [3:0] {
        OTF_ST_RUN = 4'b0001,
        OTF_ST_HICCUP = 4'b0010,
        OTF_ST_OT_HOLD = 4'b0100,
        OTF_ST_LATCHED = 4'b1000
    } otf_state_t;

    localparam int FLAG_OC_WARN = 0;
    localparam int FLAG_OC_FAULT = 1;
    localparam int FLAG_OT_FAULT = 2;
    localparam int FLAG_COUNT = 3;

endpackage

//--- logic/otf_sw_timer.sv
/*
 * otf_sw_timer: switching-period timer; makes the set pulse, the valley
 * sampling window and the two gate drives from a duty figure.
 * Assumes duty is held steady by the caller; run low stops all drive.
 */
`timescale 1ns/1ps
module otf_sw_timer
    import otf_pkg::*;
#(
    parameter int PERIOD = SW_PERIOD_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [7:0] duty,
    output logic set_pulse,
    output logic sample_win,
    output logic cycle_end,
    output logic high_side_drive,
    output logic low_side_drive
);

    localparam int SET_CYC = PERIOD / SET_FRACTION;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    generate
        if (PERIOD < 64 || PERIOD > 65535 || SET_CYC < SAMPLE_CYC) begin : g_bad
            $error("otf_sw_timer: PERIOD out of range");
        end
    endgenerate

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [23:0] prod;
    logic [15:0] on_cyc;
    logic hs_on;

    always_comb begin
        // parked on the last count so the first period after start is whole
        if (!run) begin
            cnt_d = 16'(PERIOD - 1);
        end else if (cnt_q == 16'(PERIOD - 1)) begin
            cnt_d = 16'h0000;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
        prod = 24'(duty) * 24'(PERIOD);
        on_cyc = prod[23:8];
        // high side starts as the set pulse falls
        hs_on = run && cnt_d >= 16'(SET_CYC) && (cnt_d - 16'(SET_CYC)) < on_cyc;
    end

    // ****************************************************************
    // counter and registered outputs
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            set_pulse <= 1'b0;
            sample_win <= 1'b0;
            cycle_end <= 1'b0;
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            set_pulse <= run && cnt_d < 16'(SET_CYC);
            sample_win <= run && cnt_d < 16'(SAMPLE_CYC);
            cycle_end <= run && cnt_d == 16'(PERIOD - 1);
            high_side_drive <= hs_on;
            // low side conducts through the set pulse so the valley is seen
            low_side_drive <= run && !hs_on;
        end
    end

endmodule

//--- logic/otf_telemetry.sv
/*
 * otf_telemetry: encodes output current and die temperature for the
 * management bus commands and the byte registers.
 * Assumes current in 1/16 A counts and temperature in whole degrees.
 */
`timescale 1ns/1ps
module otf_telemetry
    import otf_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] iout_code,
    input wire logic [7:0] die_temp_c,
    output logic [11:0] read_iout,
    output logic [7:0] load_current_quarter_amp,
    output logic [7:0] read_temperature,
    output logic [7:0] die_heat_offset_reading
);

    logic [7:0] temp_tens;

    always_comb begin
        temp_tens = die_temp_c / TEMP_STEP;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_iout <= IOUT_RESET;
            load_current_quarter_amp <= BYTE_RESET;
            read_temperature <= BYTE_RESET;
            die_heat_offset_reading <= BYTE_RESET;
        end else begin
            read_iout <= iout_code;
            // saturates rather than wrapping above the byte range
            if (iout_code[11:10] != 2'b00) begin
                load_current_quarter_amp <= 8'hff;
            end else begin
                load_current_quarter_amp <= iout_code[9:2];
            end
            read_temperature <= 8'(temp_tens * TEMP_STEP);
            if (die_temp_c < TEMP_OFFSET) begin
                die_heat_offset_reading <= BYTE_RESET;
            end else begin
                die_heat_offset_reading <= die_temp_c - TEMP_OFFSET;
            end
        end
    end

endmodule

//--- testbench/otf_fault_top_props.sv
/* otf_fault_top_props: port checker of the fault block.
   assumes bind onto otf_fault_top, SW_PERIOD 64 in sim. */
`timescale 1ns/1ps
module otf_fault_top_props
    import otf_pkg::*;
#(
    parameter int SW_PERIOD = 64,
    parameter int HICCUP_CYCLES = 50
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] iout_code,
    input wire logic [7:0] die_temp_c,
    input wire logic [11:0] oc_warn_limit,
    input wire logic [7:0] ot_limit,
    input wire logic [2:0] ot_response,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic set_pulse,
    input wire logic conv_active,
    input wire logic hiccup_active,
    input wire logic [1:0] duty_limit_level,
    input wire logic [11:0] read_iout,
    input wire logic [7:0] load_current_quarter_amp,
    input wire logic [7:0] read_temperature,
    input wire logic [7:0] die_heat_offset_reading,
    input wire logic oc_warn_flag,
    input wire logic oc_fault_flag,
    input wire logic ot_fault_flag
);
    // ********************
    // properties
    // ********************
    logic [15:0] hic_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk) begin
        if (!reset_n || !hiccup_active) begin
            hic_q <= 16'h0;
        end else begin
            hic_q <= hic_q + 16'h1;
        end
    end
    AST_IOUT: assert property ($past(reset_n) |-> read_iout == $past(iout_code))
        else $error("current word lost");
    AST_QUARTER: assert property ($past(reset_n) |-> load_current_quarter_amp ==
        ($past(iout_code[11:10]) != 2'h0 ? 8'hff : $past(iout_code[9:2])))
        else $error("quarter amp byte wrong");
    AST_TENS: assert property ($past(reset_n) |->
        read_temperature == 8'(($past(die_temp_c) / 10) * 10))
        else $error("coarse temperature wrong");
    AST_OFFSET: assert property ($past(reset_n) |-> die_heat_offset_reading ==
        ($past(die_temp_c) < 8'h28 ? 8'h00 : $past(die_temp_c) - 8'h28))
        else $error("offset temperature wrong");
    AST_WARN: assert property (iout_code > oc_warn_limit |=> oc_warn_flag)
        else $error("warning flag missing");
    AST_OT_STOP: assert property (die_temp_c > ot_limit && ot_response != 3'b001 |=>
        !conv_active && ot_fault_flag)
        else $error("over temperature kept running");
    AST_OT_HYST: assert property ($rose(conv_active) && $past(ot_response) != 3'b001 |->
        int'($past(die_temp_c)) + 25 < int'($past(ot_limit)))
        else $error("restart while still hot");
    AST_OFF: assert property (!conv_active [*3] |-> !high_side_drive && !low_side_drive)
        else $error("switch on while stopped");
    AST_HIC_OFF: assert property (hiccup_active |-> !conv_active)
        else $error("conversion during hiccup");
    AST_HIC_LEN: assert property ($fell(hiccup_active) |->
        hic_q >= HICCUP_CYCLES - 1 && hic_q <= HICCUP_CYCLES + 1)
        else $error("hiccup length wrong");
    AST_HIC_FLAG: assert property ($rose(hiccup_active) |-> oc_fault_flag)
        else $error("hiccup without fault flag");
    AST_SET_W: assert property ($fell(set_pulse) && conv_active |->
        $past(set_pulse, 8) && !$past(set_pulse, 9))
        else $error("set pulse width wrong");
    AST_HS_START: assert property ($rose(high_side_drive) |-> $past(set_pulse) && !set_pulse)
        else $error("high side started off the set fall");
    cover property (duty_limit_level == 2'h3);
    cover property ($rose(hiccup_active));
    cover property ($fell(conv_active) && ot_fault_flag);
endmodule
bind otf_fault_top otf_fault_top_props #(.SW_PERIOD(SW_PERIOD), .HICCUP_CYCLES(HICCUP_CYCLES))
    u_props (.clk(clk), .reset_n(reset_n), .iout_code(iout_code), .die_temp_c(die_temp_c),
    .oc_warn_limit(oc_warn_limit), .ot_limit(ot_limit), .ot_response(ot_response),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .set_pulse(set_pulse), .conv_active(conv_active), .hiccup_active(hiccup_active),
    .duty_limit_level(duty_limit_level), .read_iout(read_iout),
    .load_current_quarter_amp(load_current_quarter_amp), .read_temperature(read_temperature),
    .die_heat_offset_reading(die_heat_offset_reading), .oc_warn_flag(oc_warn_flag),
    .oc_fault_flag(oc_fault_flag), .ot_fault_flag(ot_fault_flag));

//--- testbench/otf_fault_top_tb.sv
/* otf_fault_top_tb: self-checking bench of the fault block.
   assumes 100 MHz clk; short period and hiccup keep the run brief. */
`timescale 1ns/1ps
module otf_fault_top_tb;
    import otf_pkg::*;
    localparam int P = 64;
    localparam int H = 50;
    logic clk = 1'b0, reset_n = 1'b0, conv_enable = 1'b0, overload = 1'b0;
    logic oc_comp, high_side_drive, low_side_drive, set_pulse, conv_active, hiccup_active;
    logic oc_warn_flag, oc_fault_flag, ot_fault_flag;
    logic [11:0] iout_code = 12'h000, oc_warn_limit = 12'h100, read_iout;
    logic [7:0] die_temp_c = 8'h19, ot_limit = 8'hff, duty_nominal = 8'hff;
    logic [7:0] load_current_quarter_amp, read_temperature, die_heat_offset_reading;
    logic [3:0] oc_max_count = OC_MAX_DEFAULT;
    logic [1:0] oc_response = OTF_OCR_HICCUP, duty_limit_level;
    logic [2:0] ot_response = OTF_OTR_IGNORE, status_clear = 3'h0;
    logic [35:0] exp_q[$];
    int fail_count = 0, checked = 0;
    always #5 clk = ~clk;
    otf_fault_top #(.SW_PERIOD(P), .HICCUP_CYCLES(H)) u_otf_fault_top (
        .clk(clk), .reset_n(reset_n), .conv_enable(conv_enable), .oc_comp(oc_comp),
        .iout_code(iout_code), .die_temp_c(die_temp_c), .oc_warn_limit(oc_warn_limit),
        .oc_max_count(oc_max_count), .oc_response(oc_response), .ot_limit(ot_limit),
        .ot_response(ot_response), .duty_nominal(duty_nominal), .status_clear(status_clear),
        .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
        .set_pulse(set_pulse), .conv_active(conv_active), .hiccup_active(hiccup_active),
        .duty_limit_level(duty_limit_level), .read_iout(read_iout),
        .load_current_quarter_amp(load_current_quarter_amp), .read_temperature(read_temperature),
        .die_heat_offset_reading(die_heat_offset_reading), .oc_warn_flag(oc_warn_flag),
        .oc_fault_flag(oc_fault_flag), .ot_fault_flag(ot_fault_flag));
    otf_plant u_otf_plant (.set_pulse(set_pulse), .overload(overload), .oc_comp(oc_comp));
    // ********************
    // checking helpers
    // ********************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // 0 hiccup, 1 conversion, 2..4 limit level (4 means none)
    function automatic logic pick(input int w);
        case (w)
            0: return hiccup_active;
            1: return conv_active;
            default: return duty_limit_level == w[1:0];
        endcase
    endfunction
    task automatic wt(input int w, input logic v, input int n);
        int i;
        i = 0;
        while (pick(w) !== v && i < n) begin
            @(negedge clk);
            i++;
        end
        chk(36'(pick(w)), 36'(v));
        if (pick(w) !== v) complete_run();
    endtask
    task automatic tele(input logic [11:0] i, input logic [7:0] t);
        logic [7:0] q;
        q = (i[11:10] != 2'h0) ? 8'hff : i[9:2];
        iout_code = i;
        die_temp_c = t;
        exp_q.push_back({i, q, 8'((t / 10) * 10), (t < 8'h28) ? 8'h00 : t - 8'h28});
        @(negedge clk);
    endtask
    // results land one edge after the inputs
    always @(posedge clk) begin
        if (exp_q.size() > 0) begin
            #1;
            chk({read_iout, load_current_quarter_amp, read_temperature,
                die_heat_offset_reading}, exp_q.pop_front());
        end
    end
    // ********************
    // stimulus
    // ********************
    initial begin
        void'($urandom(32'h26bc));
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        conv_enable = 1'b1;
        repeat (24) tele(12'($urandom()), 8'($urandom()));
        tele(12'h3ff, 8'h27);
        tele(12'h400, 8'h28);
        tele(12'h010, 8'h19);
        chk(36'(oc_warn_flag), 36'h1);
        status_clear = 3'h1;
        cyc(1);
        status_clear = 3'h0;
        chk(36'(oc_warn_flag), 36'h0);
        ot_limit = OT_LIMIT_DEFAULT;
        ot_response = OTF_OTR_INHIBIT;
        overload = 1'b1;
        wt(2, 1'b1, 8 * P);
        chk(36'(hiccup_active), 36'h0);
        wt(0, 1'b1, 4 * P);
        chk(36'({oc_fault_flag, conv_active}), 36'h2);
        wt(0, 1'b0, H + 4);
        wt(0, 1'b1, 10 * P);
        overload = 1'b0;
        wt(0, 1'b0, H + 4);
        cyc(12 * P);
        chk(36'({hiccup_active, conv_active}), 36'h1);
        status_clear = 3'h7;
        oc_max_count = 4'hf;
        oc_response = OTF_OCR_LATCH;
        cyc(1);
        status_clear = 3'h0;
        overload = 1'b1;
        wt(3, 1'b1, 10 * P);
        overload = 1'b0;
        wt(4, 1'b1, 14 * P);
        chk(36'(oc_fault_flag), 36'h0);
        overload = 1'b1;
        wt(1, 1'b0, 8 * P);
        overload = 1'b0;
        cyc(2 * H);
        chk(36'({hiccup_active, conv_active}), 36'h0);
        conv_enable = 1'b0;
        cyc(2);
        conv_enable = 1'b1;
        wt(1, 1'b1, 4);
        duty_nominal = 8'h10;
        oc_response = OTF_OCR_HICCUP;
        overload = 1'b1;
        cyc(7 * P);
        chk(36'(duty_limit_level), 36'h0);
        overload = 1'b0;
        die_temp_c = 8'h7e;
        cyc(1);
        chk(36'({ot_fault_flag, conv_active}), 36'h2);
        // duty raised only while stopped, never inside a running period
        duty_nominal = 8'hff;
        cyc(2);
        chk(36'({high_side_drive, low_side_drive}), 36'h0);
        die_temp_c = 8'h64;
        cyc(3);
        chk(36'(conv_active), 36'h0);
        die_temp_c = 8'h63;
        wt(1, 1'b1, 3);
        ot_response = OTF_OTR_LATCH;
        die_temp_c = 8'h7e;
        cyc(2);
        die_temp_c = 8'h40;
        cyc(4);
        chk(36'(conv_active), 36'h0);
        conv_enable = 1'b0;
        cyc(1);
        conv_enable = 1'b1;
        wt(1, 1'b1, 4);
        ot_response = OTF_OTR_IGNORE;
        die_temp_c = 8'hff;
        cyc(3);
        chk(36'(conv_active), 36'h1);
        complete_run();
    end
endmodule

//--- testbench/otf_plant.sv
/* otf_plant: valley comparator side of the power stage.
   assumes set_pulse marks the start of each valley sample. */
`timescale 1ns/1ps
module otf_plant (
    input wire logic set_pulse,
    input wire logic overload,
    output logic oc_comp
);
    // ********************
    // valley comparator
    // ********************
    // trips only near the valley, never from the adc reading
    assign oc_comp = overload & set_pulse;
endmodule
